// [bioport_pkg.sv]
/*
 * Constants for the bidirectional and input port pair: data-memory
 * addresses, widths and factory option encodings.
 * Assumes a core that reaches the ports over its data-memory bus.
 */
package bioport_pkg;
   localparam logic [7:0] BIDIR_PORT_ADDR = 8'h12;
   localparam logic [7:0] INPUT_PORT_ADDR = 8'h14;
   localparam int         BIDIR_WIDTH     = 8;
   localparam int         INPUT_WIDTH     = 4;
   localparam int         NIBBLE          = 4;
   localparam int         SYNC_STAGES     = 2;
   localparam logic [7:0] LATCH_RESET     = 8'hff;
   localparam logic [3:0] LOW_ALL_ONES    = 4'hf;
   // Low nibble structure option
   localparam logic       LOW_OPEN_DRAIN  = 1'b0;
   localparam logic       LOW_PUSH_PULL   = 1'b1;
endpackage

// [bioport_sync_if.sv]
/*
 * Carrier between the port top and its pin synchroniser.
 * Assumes both ends on sys_clk.
 */
`timescale 1ns/1ns
interface bioport_sync_if;
   logic [7:0] raw;
   logic [7:0] synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface

// [bioport_sync.sv]
/*
 * Two-flip-flop synchroniser for the port pin levels.
 * Assumes pins asynchronous to sys_clk.
 */
`timescale 1ns/1ns
module bioport_sync
(
   // Clocking
   input  wire logic      sys_clk,
   input  wire logic      rst,
   input  wire logic      clk_en,
   // Carrier
   bioport_sync_if.sync   pins
);
   logic [7:0] stage1_reg;
   logic [7:0] stage2_reg;
   logic [7:0] stage1_next;
   logic [7:0] stage2_next;

   always_comb
   begin
      stage1_next = pins.raw;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         stage1_reg <= 8'hff;
         stage2_reg <= 8'hff;
      end
      else if (clk_en)
      begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign pins.synced = stage2_reg;
endmodule

// [bioport_top.sv]
/*
 * Bidirectional 8-bit port and 4-bit input port pair, mapped as
 * data-memory bytes. Output latches drive open-drain or push-pull pins;
 * inputs are sampled, not latched, on the read strobe.
 * Assumes the core gives one-cycle rd_stb (at the second-phase edge) and
 * wr_stb (at the end of the writing cycle); pull-ups are pad controls.
 */
// Behaviour
// [R01] 8-bit bidirectional port is read and written at address 12H.
// [R02] 4-bit input-only port at 14H, pull-ups on all bits, no driver.
// [R03] High nibble always open-drain, also inputs, with pull-ups.
// [R04] Low nibble open-drain or push-pull by option; pull-ups by option.
// [R05] Each bidirectional bit individually enabled as halt wake-up source.
// [R06] Inputs unlatched; pins sampled on second-phase edge of the read.
// [R07] Written values held in latches, driving pins until rewritten.
// [R08] Software writes one to open-drain bit before reading it as input.
// [R09] After reset lines sit high or floating depending on option.
// [R10] Bit operations read pin states, modify, write back to latches.
// [R11] Software avoids read-modify-write on bidirectional port latches.
// [R12] Push-pull low nibble is output only; open-drain is input and output.
// [R13] Writes update the latch at cycle end; pins change with it.
`timescale 1ns/1ns
module bioport_top
(
   // Clocking
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       clk_en,
   // Factory options
   input  wire logic       opt_low_push_pull,
   input  wire logic       opt_low_pullup,
   input  wire logic [7:0] opt_wake_enable,
   input  wire logic       opt_reset_high,
   // Data-memory access
   input  wire logic [7:0] mem_addr,
   input  wire logic       rd_stb,
   input  wire logic       wr_stb,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data,
   output logic            rd_hit,
   // Halt wake-up
   input  wire logic       halted,
   output logic            wake_req,
   // Bidirectional port pads
   input  wire logic [7:0] bidir_port_in,
   output logic      [7:0] bidir_port_out,
   output logic      [7:0] bidir_port_oe,
   output logic      [7:0] bidir_port_pullup,
   // Input port pads
   input  wire logic [3:0] input_port_in,
   output logic      [3:0] input_port_pullup
);
   bioport_sync_if sync_bus ();

   logic [7:0] latch_reg;
   logic [7:0] latch_next;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic       armed_reg;
   logic       armed_next;
   logic [7:0] prev_pin_reg;
   logic [7:0] prev_pin_next;
   logic       wake_reg;
   logic       wake_next;
   logic [7:0] pins_now;
   logic [3:0] inport_now;
   logic [7:0] drive_low_mask;
   logic       hit_bidir;
   logic       hit_input;

   assign sync_bus.raw = {input_port_in, bidir_port_in[3:0]};

   // Upper nibble of bidirectional port gets its own separate two-stage sync
   logic [7:0] hi_s1_reg;
   logic [7:0] hi_s2_reg;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         hi_s1_reg <= 8'hff;
         hi_s2_reg <= 8'hff;
      end
      else if (clk_en)
      begin
         hi_s1_reg <= {4'hf, bidir_port_in[7:4]};
         hi_s2_reg <= hi_s1_reg;
      end
   end

   bioport_sync u_sync
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clk_en  (clk_en),
      .pins    (sync_bus.sync)
   );

   // Synchronised pad levels
   always_comb
   begin
      pins_now   = {hi_s2_reg[3:0], sync_bus.synced[3:0]};
      inport_now = sync_bus.synced[7:4];
   end

   assign hit_bidir = (mem_addr == bioport_pkg::BIDIR_PORT_ADDR);
   assign hit_input = (mem_addr == bioport_pkg::INPUT_PORT_ADDR);

   // Pin drivers follow the latch directly
   always_comb
   begin
      bidir_port_out = latch_reg; // see [R07] see [R13]
      drive_low_mask = ~latch_reg;
      bidir_port_oe[7:4] = drive_low_mask[7:4]; // see [R03]
      if (opt_low_push_pull == bioport_pkg::LOW_PUSH_PULL)
         bidir_port_oe[3:0] = bioport_pkg::LOW_ALL_ONES; // see [R04]
      else
         bidir_port_oe[3:0] = drive_low_mask[3:0]; // see [R04]
      if (rst && !opt_reset_high)
         bidir_port_oe = 8'h00; // see [R09]
      bidir_port_pullup[7:4] = 4'hf; // see [R03]
      bidir_port_pullup[3:0] = {4{opt_low_pullup}}; // see [R04]
      input_port_pullup = 4'hf; // see [R02]
   end

   // Access and wake-up next state
   always_comb
   begin
      latch_next    = latch_reg;
      rd_data_next  = rd_data_reg;
      armed_next    = armed_reg;
      prev_pin_next = pins_now;
      wake_next     = 1'b0;
      if (wr_stb && hit_bidir)
         latch_next = wr_data; // see [R01] see [R10] see [R13]
      if (rd_stb && hit_bidir)
      begin
         rd_data_next = pins_now; // see [R01] see [R06] see [R10]
         // Push-pull pins cannot be inputs: return latch instead
         if (opt_low_push_pull == bioport_pkg::LOW_PUSH_PULL)
            rd_data_next[3:0] = latch_reg[3:0]; // see [R12]
      end
      else if (rd_stb && hit_input)
         rd_data_next = {4'h0, inport_now}; // see [R02] see [R06]
      // Falling edge on an enabled bit wakes the halted core
      armed_next = halted;
      if (halted && armed_reg
          && |(opt_wake_enable & prev_pin_reg & ~pins_now))
         wake_next = 1'b1; // see [R05]
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         latch_reg    <= bioport_pkg::LATCH_RESET; // see [R09]
         rd_data_reg  <= 8'h00;
         armed_reg    <= 1'b0;
         prev_pin_reg <= 8'hff;
         wake_reg     <= 1'b0;
      end
      else if (clk_en)
      begin
         latch_reg    <= latch_next;
         rd_data_reg  <= rd_data_next;
         armed_reg    <= armed_next;
         prev_pin_reg <= prev_pin_next;
         wake_reg     <= wake_next;
      end
   end

   assign rd_data  = rd_data_reg;
   assign rd_hit   = hit_bidir | hit_input;
   assign wake_req = wake_reg;
endmodule

// [bioport_checker.sv]
/* Port pair assertions.
   Assumes a bind onto bioport_top. */
`timescale 1ns/1ns
module bioport_checker
(
   // Watched ports
   input wire logic       sys_clk, rst, clk_en, rd_stb, wr_stb, halted,
   input wire logic       opt_low_push_pull, opt_low_pullup, wake_req,
   input wire logic [7:0] mem_addr, wr_data, rd_data, bidir_port_out,
   input wire logic [7:0] bidir_port_oe, bidir_port_pullup,
   input wire logic [3:0] input_port_in, input_port_pullup
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire       wr_a = clk_en && wr_stb && mem_addr == 8'h12;
   wire       rd_a = clk_en && rd_stb && mem_addr == 8'h12;
   wire       rd_b = clk_en && rd_stb && mem_addr == 8'h14;
   wire [3:0] lo   = bidir_port_out[3:0];
   AST_WR:
      assert property (wr_a |=> bidir_port_out == $past(wr_data))
      else $error("write lost");
   AST_HOLD:
      assert property (!wr_a |=> $stable(bidir_port_out))
      else $error("latch moved");
   AST_HI_OD:
      assert property (bidir_port_oe[7:4] == ~bidir_port_out[7:4])
      else $error("high oe");
   AST_PULL:
      assert property (bidir_port_pullup == {4'hf, {4{opt_low_pullup}}}
         && input_port_pullup == 4'hf) else $error("pull-up");
   AST_LO_OE:
      assert property (!$past(rst) |-> bidir_port_oe[3:0] ==
         (opt_low_push_pull ? 4'hf : ~lo)) else $error("low oe");
   AST_RD_IN:
      assert property (rd_b && $past(input_port_in, 3) == input_port_in
         |=> rd_data == {4'h0, $past(input_port_in)}) else $error("in rd");
   AST_RD_PP:
      assert property (rd_a && opt_low_push_pull
         |=> rd_data[3:0] == $past(lo)) else $error("pp rd");
   AST_WAKE:
      assert property ($rose(wake_req) |-> $past(halted))
      else $error("wake");
   cover property (wr_a);
   cover property (rd_b);
   cover property (wake_req);
endmodule
bind bioport_top bioport_checker u_chk (.sys_clk, .rst, .clk_en, .rd_stb,
   .wr_stb, .halted, .opt_low_push_pull, .opt_low_pullup, .wake_req,
   .mem_addr, .wr_data, .rd_data, .bidir_port_out, .bidir_port_oe,
   .bidir_port_pullup, .input_port_in, .input_port_pullup);

// [bioport_board.sv]
/* Board side of the pads: pull-ups, external drivers.
   Assumes pad controls of bioport_top. */
`timescale 1ns/1ns
module bioport_board
(
   // Pad controls and outside drivers
   input wire logic       sys_clk,
   input wire logic [7:0] out, oe, pad_pullup, drv, drv_en,
   input wire logic [3:0] in_drv, in_drv_en,
   // Levels at the pads
   output logic     [7:0] pin,
   output logic     [3:0] in_pin
);
   logic t = 1'b0;
   // Floating line must not look stable
   always @(posedge sys_clk) t <= ~t;
   assign pin = (oe & out) | (~oe & drv_en & drv)
      | (~oe & ~drv_en & (pad_pullup | {8{t}}));
   assign in_pin = (in_drv_en & in_drv) | ~in_drv_en;
endmodule

// [bioport_top_tb.sv]
/* Self-checking bench for bioport_top.
   Assumes the one-cycle strobe contract of the port top. */
`timescale 1ns/1ns
module bioport_top_tb;
   logic       sys_clk = 0, rst = 1, rd_stb = 0, wr_stb = 0, halted = 0;
   logic       pp = 0, wake_req, rd_hit;
   logic [7:0] mem_addr = 0, wr_data = 0, rd_data, out, oe, pu, pin;
   logic [7:0] drv = 0, drv_en = 0;
   logic [3:0] in_drv = 0, in_pin, in_pu;
   int         error_cnt = 0, n_checks = 0, i;
   always #20 sys_clk = ~sys_clk;
   bioport_top DUT (.sys_clk, .rst, .clk_en(1'b1), .opt_low_push_pull(pp),
      .opt_low_pullup(1'b1), .opt_wake_enable(8'h01), .opt_reset_high(1'b0),
      .mem_addr, .rd_stb, .wr_stb, .wr_data, .rd_data, .rd_hit, .halted,
      .wake_req, .bidir_port_in(pin), .bidir_port_out(out),
      .bidir_port_oe(oe), .bidir_port_pullup(pu), .input_port_in(in_pin),
      .input_port_pullup(in_pu));
   bioport_board BRD (.sys_clk, .out, .oe, .pad_pullup(pu), .drv, .drv_en,
      .in_drv, .in_drv_en(4'hf), .pin, .in_pin);
   task automatic chk(input logic [7:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One access per call; strobe lives one cycle
   task automatic acc(input logic [7:0] a, d, input logic w);
      @(negedge sys_clk);
      {mem_addr, wr_data, wr_stb, rd_stb} = {a, d, w, ~w};
      @(negedge sys_clk);
      {wr_stb, rd_stb} = 2'h0;
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(negedge sys_clk);
      chk(out, 8'hff);
      chk(oe, 8'h00);
      rst = 0;
      acc(8'h12, 8'h5a, 1);
      chk(out, 8'h5a);
      chk(oe, 8'ha5);
      acc(8'h14, 8'h00, 1);
      chk(out, 8'h5a);
      $display("write test done");
      acc(8'h12, 8'hff, 1);
      {drv_en, drv, in_drv} = {8'hff, 8'h3d, 4'h9};
      repeat (3) @(negedge sys_clk);
      acc(8'h12, 8'h00, 0);
      chk(rd_data, 8'h3d);
      acc(8'h14, 8'h00, 0);
      chk(rd_data, 8'h09);
      chk({7'h00, rd_hit}, 8'h01);
      acc(8'h13, 8'h00, 0);
      chk(rd_data, 8'h09);
      chk({7'h00, rd_hit}, 8'h00);
      $display("read test done");
      halted = 1;
      repeat (3) @(negedge sys_clk);
      drv = 8'h3c;
      for (i = 0; i < 8 && wake_req !== 1'b1; i++) @(negedge sys_clk);
      chk({7'h00, wake_req}, 8'h01);
      if (wake_req !== 1'b1)
         end_sim;
      $display("wake test done");
      {halted, pp, rst} = 3'h7;
      @(negedge sys_clk);
      rst = 0;
      // Whole-byte writes only, never bit operations on the latch
      acc(8'h12, 8'hf3, 1);
      chk(oe, 8'h0f);
      acc(8'h12, 8'h00, 0);
      chk(rd_data, 8'h33);
      $display("push-pull test done");
      end_sim;
   end
endmodule
